// ==== tscr_pkg.sv ====
// Constants, field layout, reset values and types of the sensor
// configuration and result block.
// Assumes a 200 MHz system clock and APB with 32-bit data.
package tscr_pkg;

	// ****************************************************************
	// Clock and timing
	// ****************************************************************
	localparam int CLK_HZ = 200_000_000;
	localparam int CYC_PER_MS = CLK_HZ / 1000;
	localparam int CONT_CONV_MS = 240;
	localparam int ONESHOT_CONV_MS = 240;
	localparam int SPS_CONV_MS = 60;
	localparam int SPS_PERIOD_MS = 1000;
	localparam int CONT_CONV_CYC = CONT_CONV_MS * CYC_PER_MS;
	localparam int ONESHOT_CONV_CYC = ONESHOT_CONV_MS * CYC_PER_MS;
	localparam int SPS_CONV_CYC = SPS_CONV_MS * CYC_PER_MS;
	localparam int SPS_PERIOD_CYC = SPS_PERIOD_MS * CYC_PER_MS;
	localparam int TMR_W = 28;

	// ****************************************************************
	// Register map: index, byte address is four times it
	// ****************************************************************
	localparam int ADDR_W = 8;
	localparam logic [5:0] IDX_CFG = 6'h01;
	localparam logic [5:0] IDX_RESULT = 6'h02;
	localparam logic [5:0] IDX_ID = 6'h03;
	localparam logic [5:0] IDX_CRIT = 6'h04;
	localparam logic [5:0] IDX_HYST = 6'h05;
	localparam logic [5:0] IDX_HIGH = 6'h06;
	localparam logic [5:0] IDX_LOW = 6'h07;

	// ****************************************************************
	// Configuration fields
	// ****************************************************************
	localparam int CFG_FQ_LSB = 0;
	localparam int CFG_CRIT_POL = 2;
	localparam int CFG_LIM_POL = 3;
	localparam int CFG_CMP_MODE = 4;
	localparam int CFG_MODE_LSB = 5;
	localparam int CFG_RES = 7;
	localparam int FLAG_LOW = 0;
	localparam int FLAG_HIGH = 1;
	localparam int FLAG_CRIT = 2;
	localparam int HYST_SHIFT = 7;

	// ****************************************************************
	// Reset values
	// ****************************************************************
	localparam logic [7:0] CFG_RST = 8'h00;
	localparam logic [15:0] RESULT_RST = 16'h0000;
	localparam logic [15:0] CRIT_RST = 16'h4980;
	localparam logic [7:0] HYST_RST = 8'h05;
	localparam logic [15:0] HIGH_RST = 16'h2000;
	localparam logic [15:0] LOW_RST = 16'h0500;
	// Identification values are arbitrary
	localparam logic [4:0] MFR_ID_DEF = 5'h0a;
	localparam logic [2:0] REV_ID_DEF = 3'h1;

	// ****************************************************************
	// Types
	// ****************************************************************
	typedef enum logic [1:0] {
		MODE_CONT = 2'b00,
		MODE_ONESHOT = 2'b01,
		MODE_SPS = 2'b10,
		MODE_SHUT = 2'b11
	} tscr_mode_t;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_CONV = 2'b01,
		ST_WAIT = 2'b11
	} tscr_state_t;

endpackage

// ==== tscr_fq_if.sv ====
// Signals between the top block and one fault queue.
// Assumes both ends run on the system clock.
`timescale 1ns/1ps
interface tscr_fq_if;
	logic done;
	logic over;
	logic release_ok;
	logic [1:0] need;
	logic active;
	modport queue (input done, input over, input release_ok, input need, output active);
	modport owner (output done, output over, output release_ok, output need, input active);
endinterface // tscr_fq_if

// ==== tscr_fault_queue.sv ====
// Fault queue: counts consecutive out-of-limit results per alarm.
// Assumes done is a one-cycle pulse per finished conversion.
`timescale 1ns/1ps
module tscr_fault_queue (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Queue signals
	tscr_fq_if.queue fq
);
	logic [1:0] cnt_q;
	logic [1:0] cnt_d;
	logic active_q;
	logic active_d;
	wire reach = (cnt_q >= fq.need);
	wire cnt_sat = (cnt_q == 2'h3);

	// Restart on any result within the limits
	assign cnt_d = !fq.done ? cnt_q : (!fq.over ? 2'h0 : (cnt_sat ? cnt_q : cnt_q + 2'h1));
	assign active_d = (fq.done && fq.over && reach) ? 1'b1 :
		((fq.done && fq.release_ok) ? 1'b0 : active_q);
	assign fq.active = active_q;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cnt_q <= 2'h0;
			active_q <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			active_q <= active_d;
		end
	end

	// ****************************************************************
	// Checks
	// ****************************************************************
	AST_FQ_RISE: assert property (@(posedge clk_i) disable iff (rst_i)
		$rose(active_q) |-> $past(fq.done) && $past(fq.over) && $past(reach))
		else $error("alarm rose without enough faults");
	AST_FQ_RESTART: assert property (@(posedge clk_i) disable iff (rst_i)
		(fq.done && !fq.over) |=> (cnt_q == 2'h0))
		else $error("fault count not restarted");
endmodule // tscr_fault_queue

// ==== tscr_top.sv ====
// Configuration, result, limit and alarm logic of the temperature sensor.
// Assumes an APB master on the system clock and a converter front end
// that presents a 16-bit sample on the same clock.
`timescale 1ns/1ps
module tscr_top
	import tscr_pkg::*;
#(
	parameter int CONT_CYC = CONT_CONV_CYC,
	parameter int ONESHOT_CYC = ONESHOT_CONV_CYC,
	parameter int SPS_CONV_P = SPS_CONV_CYC,
	parameter int SPS_PERIOD_P = SPS_PERIOD_CYC
) (
	// Clock and reset
	input wire logic SYS_CLK_I,
	input wire logic RESET_I,
	// APB slave
	input wire logic PSEL_I,
	input wire logic PENABLE_I,
	input wire logic PWRITE_I,
	input wire logic [ADDR_W-1:0] PADDR_I,
	input wire logic [31:0] PWDATA_I,
	output logic PREADY_O,
	output logic [31:0] PRDATA_O,
	output logic PSLVERR_O,
	// Converter front end
	input wire logic [15:0] SAMPLE_I,
	output logic CONV_ACTIVE_O,
	output logic SHUTDOWN_O,
	// Alarm pins
	output logic CRIT_ALARM_O,
	output logic LIMIT_ALARM_O
);
	// ****************************************************************
	// Registers
	// ****************************************************************
	logic pready_q;
	logic pslverr_q;
	logic [31:0] prdata_q;
	logic [7:0] cfg_q;
	logic [15:0] result_q;
	logic [15:0] crit_q;
	logic [7:0] hyst_q;
	logic [15:0] high_q;
	logic [15:0] low_q;
	tscr_state_t state_q;
	tscr_state_t state_d;
	logic [TMR_W-1:0] tmr_q;
	logic [TMR_W-1:0] tmr_d;
	logic os_pend_q;
	logic crit_int_q;
	logic lim_int_q;
	logic crit_prev_q;
	logic lim_prev_q;
	logic crit_pin_q;
	logic lim_pin_q;
	logic conv_q;
	logic shut_q;

	tscr_fq_if crit_fq ();
	tscr_fq_if lim_fq ();

	// ****************************************************************
	// APB decode
	// ****************************************************************
	wire [5:0] idx = PADDR_I[ADDR_W-1:2];
	wire acc = PSEL_I && PENABLE_I && !pready_q;
	wire commit = PSEL_I && PENABLE_I && pready_q;
	wire wr = commit && PWRITE_I;
	wire rd = commit && !PWRITE_I;
	wire hit_cfg = (idx == IDX_CFG);
	wire hit_res = (idx == IDX_RESULT);
	wire hit_id = (idx == IDX_ID);
	wire hit_crit = (idx == IDX_CRIT);
	wire hit_hyst = (idx == IDX_HYST);
	wire hit_high = (idx == IDX_HIGH);
	wire hit_low = (idx == IDX_LOW);
	wire mapped = hit_cfg | hit_res | hit_id | hit_crit | hit_hyst | hit_high | hit_low;
	wire cfg_wr = wr && hit_cfg;
	wire res_rd = rd && hit_res;
	wire [7:0] id_val = {MFR_ID_DEF, REV_ID_DEF};
	wire [31:0] rdata = hit_cfg ? {24'h0, cfg_q} :
		hit_res ? {16'h0, result_q} :
		hit_id ? {24'h0, id_val} :
		hit_crit ? {16'h0, crit_q} :
		hit_hyst ? {24'h0, hyst_q} :
		hit_high ? {16'h0, high_q} :
		hit_low ? {16'h0, low_q} : 32'h0;

	// ****************************************************************
	// Configuration fields
	// ****************************************************************
	tscr_mode_t mode;
	assign mode = tscr_mode_t'(cfg_q[CFG_MODE_LSB +: 2]);
	wire res16 = cfg_q[CFG_RES];
	wire cmp_mode = cfg_q[CFG_CMP_MODE];
	wire [1:0] fq_need = cfg_q[CFG_FQ_LSB +: 2];
	wire os_wr = cfg_wr && (PWDATA_I[CFG_MODE_LSB +: 2] == MODE_ONESHOT);

	// ****************************************************************
	// Conversion sequencer
	// ****************************************************************
	wire tmr_zero = (tmr_q == '0);
	wire stop = (mode == MODE_SHUT);
	wire conv_done = (state_q == ST_CONV) && tmr_zero && !stop;
	wire start_ok = (mode == MODE_CONT) || (mode == MODE_SPS) || ((mode == MODE_ONESHOT) && os_pend_q);
	wire [TMR_W-1:0] len_cont = TMR_W'(CONT_CYC - 1);
	wire [TMR_W-1:0] len_os = TMR_W'(ONESHOT_CYC - 1);
	wire [TMR_W-1:0] len_sps = TMR_W'(SPS_CONV_P - 1);
	wire [TMR_W-1:0] len_rest = TMR_W'(SPS_PERIOD_P - SPS_CONV_P - 1);
	wire [TMR_W-1:0] len_start = (mode == MODE_CONT) ? len_cont :
		((mode == MODE_SPS) ? len_sps : len_os);
	wire start = (state_q == ST_IDLE) && start_ok;

	always_comb begin
		state_d = state_q;
		tmr_d = tmr_zero ? tmr_q : tmr_q - TMR_W'(1);
		case (state_q)
			ST_IDLE: begin
				if (start) begin
					state_d = ST_CONV;
					tmr_d = len_start;
				end
			end
			ST_CONV: begin
				if (stop) begin
					state_d = ST_IDLE;
				end else if (tmr_zero) begin
					if (mode == MODE_CONT) begin
						tmr_d = len_cont;
					end else if (mode == MODE_SPS) begin
						state_d = ST_WAIT;
						tmr_d = len_rest;
					end else begin
						state_d = ST_IDLE;
					end
				end
			end
			ST_WAIT: begin
				if (stop || mode != MODE_SPS) begin
					state_d = ST_IDLE;
				end else if (tmr_zero) begin
					state_d = ST_CONV;
					tmr_d = len_sps;
				end
			end
			default: begin
				state_d = ST_IDLE;
				tmr_d = '0;
			end
		endcase
	end

	// ****************************************************************
	// Limit comparison, values in 1/128 degree steps
	// ****************************************************************
	wire [15:0] t_cmp = res16 ? SAMPLE_I : {SAMPLE_I[15:3], 3'h0};
	wire signed [16:0] t_s = $signed({t_cmp[15], t_cmp});
	wire signed [16:0] crit_s = $signed({crit_q[15], crit_q});
	wire signed [16:0] high_s = $signed({high_q[15], high_q});
	wire signed [16:0] low_s = $signed({low_q[15], low_q});
	wire signed [16:0] hyst_s = $signed({6'h0, hyst_q[3:0], 7'h0});
	wire over_crit = t_s > crit_s;
	wire over_high = t_s > high_s;
	wire under_low = t_s < low_s;
	wire crit_rel = t_s <= (crit_s - hyst_s);
	wire lim_rel = (t_s <= (high_s - hyst_s)) && (t_s >= (low_s + hyst_s));
	wire [15:0] res_val = res16 ? SAMPLE_I :
		{SAMPLE_I[15:3], over_crit, over_high, under_low};

	assign crit_fq.done = conv_done;
	assign crit_fq.over = over_crit;
	assign crit_fq.release_ok = crit_rel;
	assign crit_fq.need = fq_need;
	assign lim_fq.done = conv_done;
	assign lim_fq.over = over_high || under_low;
	assign lim_fq.release_ok = lim_rel;
	assign lim_fq.need = fq_need;

	tscr_fault_queue u_crit_fq (
		.clk_i (SYS_CLK_I),
		.rst_i (RESET_I),
		.fq (crit_fq.queue)
	);

	tscr_fault_queue u_lim_fq (
		.clk_i (SYS_CLK_I),
		.rst_i (RESET_I),
		.fq (lim_fq.queue)
	);

	// ****************************************************************
	// Alarm pins
	// ****************************************************************
	wire crit_rise = crit_fq.active && !crit_prev_q;
	wire lim_rise = lim_fq.active && !lim_prev_q;
	wire crit_int_d = crit_rise || (crit_int_q && !res_rd);
	wire lim_int_d = lim_rise || (lim_int_q && !res_rd);
	wire crit_act = cmp_mode ? crit_fq.active : crit_int_q;
	wire lim_act = cmp_mode ? lim_fq.active : lim_int_q;
	wire crit_pin_d = cfg_q[CFG_CRIT_POL] ? crit_act : !crit_act;
	wire lim_pin_d = cfg_q[CFG_LIM_POL] ? lim_act : !lim_act;

	// ****************************************************************
	// Flip-flops
	// ****************************************************************
	always_ff @(posedge SYS_CLK_I) begin
		if (RESET_I) begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= 32'h0;
		end else begin
			pready_q <= acc;
			pslverr_q <= acc && !mapped;
			if (acc) begin
				prdata_q <= PWRITE_I ? 32'h0 : rdata;
			end
		end
	end

	always_ff @(posedge SYS_CLK_I) begin
		if (RESET_I) begin
			cfg_q <= CFG_RST;
			crit_q <= CRIT_RST;
			hyst_q <= HYST_RST;
			high_q <= HIGH_RST;
			low_q <= LOW_RST;
		end else if (wr) begin
			if (hit_cfg) cfg_q <= PWDATA_I[7:0];
			if (hit_crit) crit_q <= PWDATA_I[15:0];
			if (hit_hyst) hyst_q <= PWDATA_I[7:0];
			if (hit_high) high_q <= PWDATA_I[15:0];
			if (hit_low) low_q <= PWDATA_I[15:0];
		end
	end

	always_ff @(posedge SYS_CLK_I) begin
		if (RESET_I) begin
			result_q <= RESULT_RST;
		end else if (conv_done) begin
			result_q <= res_val;
		end
	end

	always_ff @(posedge SYS_CLK_I) begin
		if (RESET_I) begin
			state_q <= ST_IDLE;
			tmr_q <= '0;
			os_pend_q <= 1'b0;
		end else begin
			state_q <= state_d;
			tmr_q <= tmr_d;
			os_pend_q <= os_wr || (os_pend_q && !start);
		end
	end

	always_ff @(posedge SYS_CLK_I) begin
		if (RESET_I) begin
			crit_int_q <= 1'b0;
			lim_int_q <= 1'b0;
			crit_prev_q <= 1'b0;
			lim_prev_q <= 1'b0;
			crit_pin_q <= 1'b1;
			lim_pin_q <= 1'b1;
			conv_q <= 1'b0;
			shut_q <= 1'b0;
		end else begin
			crit_int_q <= crit_int_d;
			lim_int_q <= lim_int_d;
			crit_prev_q <= crit_fq.active;
			lim_prev_q <= lim_fq.active;
			crit_pin_q <= crit_pin_d;
			lim_pin_q <= lim_pin_d;
			conv_q <= (state_d == ST_CONV);
			shut_q <= (mode == MODE_SHUT);
		end
	end

	assign PREADY_O = pready_q;
	assign PSLVERR_O = pslverr_q;
	assign PRDATA_O = prdata_q;
	assign CONV_ACTIVE_O = conv_q;
	assign SHUTDOWN_O = shut_q;
	assign CRIT_ALARM_O = crit_pin_q;
	assign LIMIT_ALARM_O = lim_pin_q;

	// ****************************************************************
	// Checks
	// ****************************************************************
	AST_CRIT_PIN: assert property (@(posedge SYS_CLK_I) disable iff (RESET_I)
		(crit_act && !cfg_wr) |=> (CRIT_ALARM_O == $past(cfg_q[CFG_CRIT_POL])))
		else $error("critical pin not at active level");
	AST_LIM_PIN: assert property (@(posedge SYS_CLK_I) disable iff (RESET_I)
		(!lim_act && !cfg_wr) |=> (LIMIT_ALARM_O != $past(cfg_q[CFG_LIM_POL])))
		else $error("limit pin not at idle level");
	AST_INT_HOLD: assert property (@(posedge SYS_CLK_I) disable iff (RESET_I)
		(crit_int_q && !res_rd) |=> crit_int_q)
		else $error("interrupt latch dropped early");
	AST_CONT: assert property (@(posedge SYS_CLK_I) disable iff (RESET_I)
		(conv_done && mode == MODE_CONT) |=> (state_q == ST_CONV) && (tmr_q == len_cont))
		else $error("continuous mode did not restart");
	AST_ONESHOT: assert property (@(posedge SYS_CLK_I) disable iff (RESET_I)
		(conv_done && mode == MODE_ONESHOT) |=> (state_q == ST_IDLE))
		else $error("one-shot did not stop");
	AST_SPS: assert property (@(posedge SYS_CLK_I) disable iff (RESET_I)
		(conv_done && mode == MODE_SPS) |=> (state_q == ST_WAIT) && (tmr_q == len_rest))
		else $error("once-per-second wait not entered");
	AST_SHUT: assert property (@(posedge SYS_CLK_I) disable iff (RESET_I)
		(stop && !cfg_wr) |=> (state_q == ST_IDLE) ##1 SHUTDOWN_O)
		else $error("shutdown not honoured");
	AST_RES16: assert property (@(posedge SYS_CLK_I) disable iff (RESET_I)
		(conv_done && res16) |=> (result_q == $past(SAMPLE_I)))
		else $error("16-bit result wrong");
	AST_RO: assert property (@(posedge SYS_CLK_I) disable iff (RESET_I)
		(wr && hit_res && !conv_done) |=> $stable(result_q))
		else $error("result register was written");
	AST_FLAG_LOW: assert property (@(posedge SYS_CLK_I) disable iff (RESET_I)
		(conv_done && !res16 && !wr) |=>
		(result_q[FLAG_LOW] == ($signed({result_q[15:3], 3'h0}) < $signed(low_q))))
		else $error("low flag wrong");
	AST_FLAG_HIGH: assert property (@(posedge SYS_CLK_I) disable iff (RESET_I)
		(conv_done && !res16 && !wr) |=>
		(result_q[FLAG_HIGH] == ($signed({result_q[15:3], 3'h0}) > $signed(high_q))))
		else $error("high flag wrong");
	AST_FLAG_CRIT: assert property (@(posedge SYS_CLK_I) disable iff (RESET_I)
		(conv_done && !res16 && !wr) |=>
		(result_q[FLAG_CRIT] == ($signed({result_q[15:3], 3'h0}) > $signed(crit_q))))
		else $error("critical flag wrong");
	AST_APB_ANS: assert property (@(posedge SYS_CLK_I) disable iff (RESET_I)
		acc |=> PREADY_O ##1 !PREADY_O)
		else $error("bus answer not one cycle");

	COV_CRIT_ALARM: cover property (@(posedge SYS_CLK_I) disable iff (RESET_I)
		$rose(crit_fq.active));
	COV_ONESHOT: cover property (@(posedge SYS_CLK_I) disable iff (RESET_I)
		conv_done && mode == MODE_ONESHOT);
	COV_SPS_WAIT: cover property (@(posedge SYS_CLK_I) disable iff (RESET_I)
		state_q == ST_WAIT ##1 state_q == ST_CONV);
	COV_FLAG_READ: cover property (@(posedge SYS_CLK_I) disable iff (RESET_I)
		res_rd && !res16 && result_q[FLAG_HIGH]);
endmodule // tscr_top

// ==== tscr_front_model.sv ====
// Behavioural converter front end facing the sensor block.
// Assumes the sample is only meaningful while a conversion runs.
`timescale 1ns/1ps
module tscr_front_model (
	// Converter status from the block
	input wire logic conv_active_i,
	input wire logic shutdown_i,
	// Temperature chosen by the bench
	input wire logic [15:0] temp_i,
	// Sample to the block
	output logic [15:0] sample_o
);
	// ****************************************************************
	// Sample drive
	// ****************************************************************
	// Outside a conversion the sample is stale: show its inverse
	assign sample_o = (conv_active_i && !shutdown_i) ? temp_i : ~temp_i;
endmodule // tscr_front_model

// ==== testbench.sv ====
// Self-checking bench for the sensor configuration and result block.
// Assumes the block answers APB with its own wait states.
`timescale 1ns/1ps
module testbench;
	import tscr_pkg::*;
	localparam int CONT_N = 20;
	localparam int ONE_N = 30;
	localparam int SPS_N = 15;
	localparam int SPS_P = 60;
	logic sys_clk = 1'b0;
	logic reset = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [ADDR_W-1:0] paddr = '0;
	logic [31:0] pwdata = '0;
	logic [15:0] temp = 16'h0c85;
	wire logic pready;
	wire logic [31:0] prdata;
	wire logic pslverr;
	wire logic [15:0] sample;
	wire logic conv_active;
	wire logic shutdown;
	wire logic crit_alarm;
	wire logic limit_alarm;
	int fail_count = 0;
	int checked = 0;
	int cyc = 0;
	int n;
	int m;
	logic [31:0] rd;
	logic [15:0] tv [4] = '{16'h0400, 16'h4a00, 16'h1e00, 16'h0c80};
	logic ec [4] = '{1'b0, 1'b1, 1'b0, 1'b0};
	logic el [4] = '{1'b1, 1'b1, 1'b1, 1'b0};

	always #2.5 sys_clk = ~sys_clk;

	tscr_top #(
		.CONT_CYC(CONT_N),
		.ONESHOT_CYC(ONE_N),
		.SPS_CONV_P(SPS_N),
		.SPS_PERIOD_P(SPS_P)
	) i_dut (
		.SYS_CLK_I(sys_clk),
		.RESET_I(reset),
		.PSEL_I(psel),
		.PENABLE_I(penable),
		.PWRITE_I(pwrite),
		.PADDR_I(paddr),
		.PWDATA_I(pwdata),
		.PREADY_O(pready),
		.PRDATA_O(prdata),
		.PSLVERR_O(pslverr),
		.SAMPLE_I(sample),
		.CONV_ACTIVE_O(conv_active),
		.SHUTDOWN_O(shutdown),
		.CRIT_ALARM_O(crit_alarm),
		.LIMIT_ALARM_O(limit_alarm)
	);

	tscr_front_model i_front (
		.conv_active_i(conv_active),
		.shutdown_i(shutdown),
		.temp_i(temp),
		.sample_o(sample)
	);

	// ****************************************************************
	// Verdict, compares and bus tasks
	// ****************************************************************
	task automatic report_and_stop;
		if (fail_count == 0 && checked > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask

	task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			fail_count++;
			$display("unexpected at %0t: word %h, wanted %h", $time, got, exp);
		end
	endtask

	task automatic check_pin(input logic got, input logic exp);
		checked++;
		if (got !== exp) begin
			fail_count++;
			$display("unexpected at %0t: pin %b, wanted %b", $time, got, exp);
		end
	endtask

	task automatic apb(input logic wr, input logic [5:0] idx, input logic [31:0] wd,
		input logic exp_err);
		@(posedge sys_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= {idx, 2'b00};
		pwdata <= wd;
		@(posedge sys_clk);
		penable <= 1'b1;
		do begin
			@(posedge sys_clk);
		end while (pready !== 1'b1);
		rd = prdata;
		check_pin(pslverr, exp_err);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic reg_wr(input logic [5:0] idx, input logic [31:0] wd);
		apb(1'b1, idx, wd, 1'b0);
	endtask

	task automatic reg_chk(input logic [5:0] idx, input logic [31:0] exp);
		apb(1'b0, idx, '0, 1'b0);
		check_word(rd, exp);
	endtask

	task automatic settle(input int k);
		repeat (k) @(posedge sys_clk);
	endtask

	task automatic set_temp(input logic [15:0] t);
		@(posedge sys_clk);
		temp <= t;
	endtask

	// Cycles until the conversion flag reaches the level
	task automatic wait_conv(input logic lvl, output int k);
		k = 0;
		while (conv_active !== lvl && k < 2000) begin
			@(posedge sys_clk);
			k++;
		end
	endtask

	function automatic logic [31:0] exp13(input logic [15:0] t);
		logic signed [15:0] v;
		v = {t[15:3], 3'b000};
		return {16'h0000, t[15:3], v > $signed(CRIT_RST), v > $signed(HIGH_RST),
			v < $signed(LOW_RST)};
	endfunction

	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 8000) begin
			fail_count++;
			$display("unexpected at %0t: run too long", $time);
			report_and_stop;
		end
	end

	// ****************************************************************
	// Main sequence
	// ****************************************************************
	initial begin
		repeat (12) @(posedge sys_clk);
		reset <= 1'b0;
		reg_wr(IDX_RESULT, 32'h7777);
		reg_chk(IDX_RESULT, {16'h0000, RESULT_RST});
		reg_chk(IDX_CFG, {24'h0, CFG_RST});
		reg_chk(IDX_CRIT, {16'h0000, CRIT_RST});
		reg_wr(IDX_ID, 32'hff);
		reg_chk(IDX_ID, {24'h0, MFR_ID_DEF, REV_ID_DEF});
		check_pin(crit_alarm, 1'b1);
		check_pin(limit_alarm, 1'b1);
		apb(1'b0, 6'h00, '0, 1'b1);
		check_word(rd, 32'h0);
		apb(1'b1, 6'h08, 32'h5, 1'b1);
		reg_wr(IDX_CRIT, 32'h1234);
		reg_chk(IDX_CRIT, 32'h1234);
		reg_wr(IDX_CRIT, {16'h0000, CRIT_RST});
		reg_wr(IDX_CFG, 32'h1c);
		reg_chk(IDX_CFG, 32'h1c);
		settle(3 * CONT_N + 10);
		reg_chk(IDX_RESULT, exp13(16'h0c85));
		for (int i = 0; i < 4; i++) begin
			set_temp(tv[i]);
			settle(3 * CONT_N + 10);
			reg_chk(IDX_RESULT, exp13(tv[i]));
			check_pin(crit_alarm, ec[i]);
			check_pin(limit_alarm, el[i]);
		end
		reg_wr(IDX_CFG, 32'h0c);
		set_temp(16'h4a00);
		settle(3 * CONT_N + 10);
		check_pin(crit_alarm, 1'b1);
		set_temp(16'h0c80);
		settle(3 * CONT_N + 10);
		check_pin(crit_alarm, 1'b1);
		reg_chk(IDX_RESULT, exp13(16'h0c80));
		settle(4);
		check_pin(crit_alarm, 1'b0);
		check_pin(limit_alarm, 1'b0);
		reg_wr(IDX_CFG, 32'h1f);
		set_temp(16'h4a00);
		settle(2 * CONT_N + 5);
		check_pin(crit_alarm, 1'b0);
		settle(5 * CONT_N);
		check_pin(crit_alarm, 1'b1);
		set_temp(16'h0c80);
		settle(3 * CONT_N + 10);
		reg_wr(IDX_CFG, 32'h80);
		set_temp(16'h0c85);
		settle(3 * CONT_N + 10);
		check_pin(crit_alarm, 1'b0);
		check_pin(limit_alarm, 1'b0);
		reg_chk(IDX_RESULT, 32'h0c85);
		settle(2);
		check_pin(crit_alarm, 1'b1);
		reg_wr(IDX_CFG, 32'he0);
		settle(3);
		check_pin(shutdown, 1'b1);
		check_pin(conv_active, 1'b0);
		set_temp(16'h1111);
		settle(3 * CONT_N);
		reg_chk(IDX_RESULT, 32'h0c85);
		reg_chk(IDX_CFG, 32'he0);
		reg_wr(IDX_CFG, 32'ha0);
		wait_conv(1'b1, n);
		wait_conv(1'b0, n);
		check_word(32'(n), 32'(ONE_N));
		settle(3);
		reg_chk(IDX_RESULT, 32'h1111);
		set_temp(16'h2222);
		settle(2 * ONE_N);
		check_pin(conv_active, 1'b0);
		reg_chk(IDX_RESULT, 32'h1111);
		reg_wr(IDX_CFG, 32'hc0);
		wait_conv(1'b1, n);
		wait_conv(1'b0, n);
		check_word(32'(n), 32'(SPS_N));
		wait_conv(1'b1, m);
		check_word(32'(n + m), 32'(SPS_P));
		wait_conv(1'b0, n);
		settle(3);
		reg_chk(IDX_RESULT, 32'h2222);
		report_and_stop;
	end
endmodule // testbench
